// File: hw/smotr_pkg.sv
// Package with register map, field layout and reset values of the opmode and timing stage.
`default_nettype none
package smotr_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] ADDR_COMMAND = 8'h00;
	localparam logic [7:0] ADDR_STAGED_TIMING = 8'h04;
	localparam logic [7:0] ADDR_STAGED_MODE = 8'h08;
	localparam logic [7:0] ADDR_TIMING_BANK0 = 8'h10;
	localparam logic [7:0] ADDR_TIMING_BANK1 = 8'h14;
	localparam logic [7:0] ADDR_MODE_BANK0 = 8'h20;
	localparam logic [7:0] ADDR_MODE_BANK1 = 8'h24;
	// ==========================================================
	// Command register fields
	localparam int CMD_CS_LSB = 23;
	localparam int CMD_CS_MSB = 25;
	localparam int CMD_TYPE_LSB = 21;
	localparam int CMD_TYPE_MSB = 22;
	localparam logic [1:0] CMD_UPDATE = 2'h2;
	localparam logic [2:0] CS_BANK0 = 3'h0;
	localparam logic [2:0] CS_BANK1 = 3'h1;
	// ==========================================================
	// Operating mode fields
	localparam int MODE_LATCH_BIT = 11;
	localparam int MODE_BURST_LSB = 3;
	localparam int MODE_BURST_MSB = 5;
	localparam int MODE_WIDTH_LSB = 0;
	localparam int MODE_WIDTH_MSB = 1;
	localparam logic [2:0] BURST_SINGLE = 3'h0;
	localparam logic [2:0] BURST_FOUR = 3'h1;
	localparam logic [1:0] WIDTH_16BIT = 2'h1;
	localparam logic [31:0] MODE_WRITE_MASK = 32'h0000_0838;
	localparam logic [31:0] MODE_RESET = 32'h0000_0801;
	// ==========================================================
	// Timing fields
	localparam int TR_LSB = 17;
	localparam int TR_MSB = 19;
	localparam int PC_LSB = 14;
	localparam int PC_MSB = 16;
	localparam int WP_LSB = 11;
	localparam int WP_MSB = 13;
	localparam int CEOE_LSB = 8;
	localparam int CEOE_MSB = 10;
	localparam int WC_LSB = 4;
	localparam int WC_MSB = 7;
	localparam int RC_LSB = 0;
	localparam int RC_MSB = 3;
	localparam logic [31:0] TIMING_MASK = 32'h000F_FFFF;
	localparam logic [31:0] TIMING_RESET = 32'h0006_B3CC;
	// ==========================================================
	// Controller clock runs at half the system clock.
	localparam logic [0:0] CTRL_DIV_LAST = 1'h1;
	localparam int SYS_PER_CTRL_SHIFT = 1;
	typedef enum logic [0:0] {
		SMOTR_BANK0 = 1'b0,
		SMOTR_BANK1 = 1'b1
	} smotr_bank_t;
endpackage
`default_nettype wire

// File: hw/smotr_top.sv
// Staging and per-chip-select active registers of the static memory opmode and timing stage.
`default_nettype none
// What this block does
// - Latch bit 0 selects separate bus without latch strobe, 1 multiplexed with strobe.
// - Burst code 000 is one beat, 001 four beats, others reserved.
// - Bus width code 01 means 16-bit bus; other codes reserved.
// - Staged mode has no effect until the update command copies it to a chip select.
// - Turnaround field 001 to 111 reports one to seven controller cycles.
// - Page field 001 to 111 reports one to seven controller cycles per beat.
// - Write pulse field 001 to 111 reports one to seven controller cycles.
// - Output enable delay field 001 to 111 reports one to seven controller cycles.
// - Write cycle field 0011 to 1111 reports three to fifteen controller cycles.
// - Read cycle field 0010 to 1111 reports two to fifteen controller cycles.
// - No page accesses on a multiplexed bus; page timing only for separate bus.
// - Only command type 10 transfers staged values; other codes are prohibited.
// - All field cycle counts are in the controller clock at half the system clock; the timing outputs double them into system clock cycles.
module smotr_top (
	// Clock and reset.
	input wire logic mclk,
	input wire logic nrst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// Controller clock enable.
	output logic memory_ctrl_clock,
	// Active settings of bank 0.
	output logic bank0_latch_used,
	output logic bank0_page_enable,
	output logic [2:0] bank0_read_beats,
	output logic [1:0] bank0_bus_width,
	// Active settings of bank 1.
	output logic bank1_latch_used,
	output logic bank1_page_enable,
	output logic [2:0] bank1_read_beats,
	output logic [1:0] bank1_bus_width,
	// Active timing of bank 0 in system clock cycles.
	output logic [4:0] bank0_turnaround_cycles,
	output logic [4:0] bank0_page_beat_cycles,
	output logic [4:0] bank0_write_pulse_cycles,
	output logic [4:0] bank0_oe_delay_cycles,
	output logic [4:0] bank0_write_cycle_length,
	output logic [4:0] bank0_read_cycle_length,
	// Active timing of bank 1 in system clock cycles.
	output logic [4:0] bank1_turnaround_cycles,
	output logic [4:0] bank1_page_beat_cycles,
	output logic [4:0] bank1_write_pulse_cycles,
	output logic [4:0] bank1_oe_delay_cycles,
	output logic [4:0] bank1_write_cycle_length,
	output logic [4:0] bank1_read_cycle_length
);
	// ==========================================================
	// Helper functions
	// Converts a count of controller cycles into system clock cycles.
	function automatic logic [4:0] to_sys(input logic [3:0] ctrl_cycles);
		to_sys = {ctrl_cycles, 1'b0} << (smotr_pkg::SYS_PER_CTRL_SHIFT - 1);
	endfunction

	// Reduces a staged mode word to its legal fields, forcing reserved codes to safe values.
	function automatic logic [31:0] legal_mode(input logic [31:0] staged);
		logic [31:0] result;
		logic [2:0] burst;
		logic [1:0] width;
		result = staged & smotr_pkg::MODE_WRITE_MASK;
		burst = staged[smotr_pkg::MODE_BURST_MSB:smotr_pkg::MODE_BURST_LSB];
		width = staged[smotr_pkg::MODE_WIDTH_MSB:smotr_pkg::MODE_WIDTH_LSB];
		if (burst != smotr_pkg::BURST_FOUR) begin
			burst = smotr_pkg::BURST_SINGLE;
		end
		if (width != smotr_pkg::WIDTH_16BIT) begin
			width = smotr_pkg::WIDTH_16BIT;
		end
		result[smotr_pkg::MODE_BURST_MSB:smotr_pkg::MODE_BURST_LSB] = burst;
		result[smotr_pkg::MODE_WIDTH_MSB:smotr_pkg::MODE_WIDTH_LSB] = width;
		legal_mode = result;
	endfunction

	// Page accesses are allowed only on the separate bus with a four-beat read.
	function automatic logic page_ok(input logic [31:0] mode);
		page_ok = !mode[smotr_pkg::MODE_LATCH_BIT] &&
			(mode[smotr_pkg::MODE_BURST_MSB:smotr_pkg::MODE_BURST_LSB] ==
			smotr_pkg::BURST_FOUR);
	endfunction

	// ==========================================================
	// Registers
	logic ctrl_div;
	logic [31:0] staged_operating_mode;
	logic [31:0] staged_timing;
	logic [31:0] active_timing_bank0;
	logic [31:0] active_timing_bank1;
	logic [31:0] active_mode_bank0;
	logic [31:0] active_mode_bank1;

	// ==========================================================
	// Address and command decoding
	wire sel_command = reg_addr == smotr_pkg::ADDR_COMMAND;
	wire sel_staged_timing = reg_addr == smotr_pkg::ADDR_STAGED_TIMING;
	wire sel_staged_mode = reg_addr == smotr_pkg::ADDR_STAGED_MODE;
	wire sel_timing0 = reg_addr == smotr_pkg::ADDR_TIMING_BANK0;
	wire sel_timing1 = reg_addr == smotr_pkg::ADDR_TIMING_BANK1;
	wire sel_mode0 = reg_addr == smotr_pkg::ADDR_MODE_BANK0;
	wire sel_mode1 = reg_addr == smotr_pkg::ADDR_MODE_BANK1;
	wire [1:0] cmd_type = reg_wdata[smotr_pkg::CMD_TYPE_MSB:smotr_pkg::CMD_TYPE_LSB];
	wire [2:0] cmd_cs = reg_wdata[smotr_pkg::CMD_CS_MSB:smotr_pkg::CMD_CS_LSB];
	wire cmd_update = reg_write && sel_command && (cmd_type == smotr_pkg::CMD_UPDATE);
	wire update_bank0 = cmd_update && (cmd_cs == smotr_pkg::CS_BANK0);
	wire update_bank1 = cmd_update && (cmd_cs == smotr_pkg::CS_BANK1);
	wire [31:0] next_active_mode = legal_mode(staged_operating_mode);
	wire [31:0] next_active_timing = staged_timing & smotr_pkg::TIMING_MASK;

	// ==========================================================
	// Read data selection
	logic [31:0] read_value;
	always_comb begin
		if (sel_timing0) begin
			read_value = active_timing_bank0;
		end else if (sel_timing1) begin
			read_value = active_timing_bank1;
		end else if (sel_mode0) begin
			read_value = active_mode_bank0;
		end else if (sel_mode1) begin
			read_value = active_mode_bank1;
		end else begin
			read_value = 32'h0000_0000;
		end
	end

	// ==========================================================
	// Controller clock enable
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_div <= 1'h0;
		end else begin
			ctrl_div <= ctrl_div ^ 1'h1;
		end
	end
	assign memory_ctrl_clock = ctrl_div == smotr_pkg::CTRL_DIV_LAST;

	// ==========================================================
	// Staging registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			staged_operating_mode <= smotr_pkg::MODE_RESET;
		end else if (reg_write && sel_staged_mode) begin
			staged_operating_mode <= reg_wdata & smotr_pkg::MODE_WRITE_MASK;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			staged_timing <= smotr_pkg::TIMING_RESET;
		end else if (reg_write && sel_staged_timing) begin
			staged_timing <= reg_wdata & smotr_pkg::TIMING_MASK;
		end
	end

	// ==========================================================
	// Active registers of bank 0
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			active_timing_bank0 <= smotr_pkg::TIMING_RESET;
			active_mode_bank0 <= smotr_pkg::MODE_RESET;
		end else if (update_bank0) begin
			active_timing_bank0 <= next_active_timing;
			active_mode_bank0 <= next_active_mode;
		end
	end

	// ==========================================================
	// Active registers of bank 1
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			active_timing_bank1 <= smotr_pkg::TIMING_RESET;
			active_mode_bank1 <= smotr_pkg::MODE_RESET;
		end else if (update_bank1) begin
			active_timing_bank1 <= next_active_timing;
			active_mode_bank1 <= next_active_mode;
		end
	end

	// ==========================================================
	// Read data register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_read) begin
			reg_rdata <= read_value;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// Mode outputs
	assign bank0_latch_used = active_mode_bank0[smotr_pkg::MODE_LATCH_BIT];
	assign bank1_latch_used = active_mode_bank1[smotr_pkg::MODE_LATCH_BIT];
	assign bank0_page_enable = page_ok(active_mode_bank0);
	assign bank1_page_enable = page_ok(active_mode_bank1);
	assign bank0_read_beats =
		active_mode_bank0[smotr_pkg::MODE_BURST_MSB:smotr_pkg::MODE_BURST_LSB];
	assign bank1_read_beats =
		active_mode_bank1[smotr_pkg::MODE_BURST_MSB:smotr_pkg::MODE_BURST_LSB];
	assign bank0_bus_width =
		active_mode_bank0[smotr_pkg::MODE_WIDTH_MSB:smotr_pkg::MODE_WIDTH_LSB];
	assign bank1_bus_width =
		active_mode_bank1[smotr_pkg::MODE_WIDTH_MSB:smotr_pkg::MODE_WIDTH_LSB];

	// ==========================================================
	// Timing outputs of bank 0
	assign bank0_turnaround_cycles =
		to_sys({1'b0, active_timing_bank0[smotr_pkg::TR_MSB:smotr_pkg::TR_LSB]});
	assign bank0_page_beat_cycles = bank0_page_enable ?
		to_sys({1'b0, active_timing_bank0[smotr_pkg::PC_MSB:smotr_pkg::PC_LSB]}) :
		5'h00;
	assign bank0_write_pulse_cycles =
		to_sys({1'b0, active_timing_bank0[smotr_pkg::WP_MSB:smotr_pkg::WP_LSB]});
	assign bank0_oe_delay_cycles =
		to_sys({1'b0, active_timing_bank0[smotr_pkg::CEOE_MSB:smotr_pkg::CEOE_LSB]});
	assign bank0_write_cycle_length =
		to_sys(active_timing_bank0[smotr_pkg::WC_MSB:smotr_pkg::WC_LSB]);
	assign bank0_read_cycle_length =
		to_sys(active_timing_bank0[smotr_pkg::RC_MSB:smotr_pkg::RC_LSB]);

	// ==========================================================
	// Timing outputs of bank 1
	assign bank1_turnaround_cycles =
		to_sys({1'b0, active_timing_bank1[smotr_pkg::TR_MSB:smotr_pkg::TR_LSB]});
	assign bank1_page_beat_cycles = bank1_page_enable ?
		to_sys({1'b0, active_timing_bank1[smotr_pkg::PC_MSB:smotr_pkg::PC_LSB]}) :
		5'h00;
	assign bank1_write_pulse_cycles =
		to_sys({1'b0, active_timing_bank1[smotr_pkg::WP_MSB:smotr_pkg::WP_LSB]});
	assign bank1_oe_delay_cycles =
		to_sys({1'b0, active_timing_bank1[smotr_pkg::CEOE_MSB:smotr_pkg::CEOE_LSB]});
	assign bank1_write_cycle_length =
		to_sys(active_timing_bank1[smotr_pkg::WC_MSB:smotr_pkg::WC_LSB]);
	assign bank1_read_cycle_length =
		to_sys(active_timing_bank1[smotr_pkg::RC_MSB:smotr_pkg::RC_LSB]);
endmodule
`default_nettype wire

// File: dv/smotr_assertions.sv
// Checker of the opmode and timing stage ports.
`default_nettype none
module smotr_assertions (
	// Clock and reset.
	input wire logic mclk,
	input wire logic nrst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	// Active settings.
	input wire logic memory_ctrl_clock,
	input wire logic bank0_latch_used,
	input wire logic bank0_page_enable,
	input wire logic [2:0] bank0_read_beats,
	input wire logic [1:0] bank1_bus_width,
	input wire logic [4:0] bank0_page_beat_cycles,
	input wire logic [4:0] bank0_turnaround_cycles,
	input wire logic [4:0] bank1_read_cycle_length
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// Properties.
	property p_idle; !$past(reg_read) |-> reg_rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data outside read slot");
	property p_tr; reg_read && reg_addr == smotr_pkg::ADDR_TIMING_BANK0
		|=> reg_rdata[19:17] == $past(bank0_turnaround_cycles[3:1]); endproperty
	a_tr: assert property (p_tr) else $error("turnaround readback mismatch");
	property p_mux; bank0_latch_used |-> !bank0_page_enable; endproperty
	a_mux: assert property (p_mux) else $error("page mode on multiplexed bus");
	property p_pz; !bank0_page_enable |-> bank0_page_beat_cycles == 5'h00; endproperty
	a_pz: assert property (p_pz) else $error("page time without page mode");
	property p_bl; bank0_read_beats inside {3'h0, 3'h1}; endproperty
	a_bl: assert property (p_bl) else $error("reserved burst active");
	property p_mw; bank1_bus_width == 2'h1; endproperty
	a_mw: assert property (p_mw) else $error("bus width not 16 bit");
	property p_div; memory_ctrl_clock |=> !memory_ctrl_clock ##1 memory_ctrl_clock; endproperty
	a_div: assert property (p_div) else $error("controller clock not half rate");
	property p_stg; reg_write && reg_addr == smotr_pkg::ADDR_STAGED_MODE
		|=> $stable(bank0_latch_used) && $stable(bank0_read_beats) &&
		$stable(bank1_read_cycle_length); endproperty
	a_stg: assert property (p_stg) else $error("staged write took effect");
endmodule
bind smotr_top smotr_assertions u_smotr_assertions (.mclk, .nrst, .reg_addr, .reg_write,
	.reg_read, .reg_rdata, .memory_ctrl_clock, .bank0_latch_used, .bank0_page_enable,
	.bank0_read_beats, .bank1_bus_width, .bank0_page_beat_cycles, .bank0_turnaround_cycles,
	.bank1_read_cycle_length);
`default_nettype wire

// File: dv/smotr_sram_model.sv
// Model of the static memory that consumes one bank's settings.
`default_nettype none
module smotr_sram_model (
	// Clock and reset.
	input wire logic mclk,
	input wire logic nrst,
	// Settings seen by the memory.
	input wire logic memory_ctrl_clock,
	input wire logic latch_used,
	input wire logic page_enable,
	// Status.
	output logic page_on_mux,
	output logic [7:0] ctrl_ticks
);
	timeunit 1ns;
	timeprecision 1ps;
	// A memory on a multiplexed bus cannot take page bursts.
	assign page_on_mux = latch_used & page_enable;
	// Counts controller clock ticks seen by the memory.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_ticks <= 8'h00;
		end else if (memory_ctrl_clock) begin
			ctrl_ticks <= ctrl_ticks + 8'h01;
		end
	end
endmodule
`default_nettype wire

// File: dv/smotr_top_test.sv
// Testbench of the opmode and timing stage.
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module smotr_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic memory_ctrl_clock, bank0_latch_used, bank0_page_enable, bank1_latch_used;
	logic bank1_page_enable, page_on_mux;
	logic [2:0] bank0_read_beats, bank1_read_beats;
	logic [1:0] bank0_bus_width, bank1_bus_width;
	logic [4:0] bank0_turnaround_cycles, bank0_page_beat_cycles, bank0_write_pulse_cycles;
	logic [4:0] bank0_oe_delay_cycles, bank0_write_cycle_length, bank0_read_cycle_length;
	logic [4:0] bank1_turnaround_cycles, bank1_page_beat_cycles, bank1_write_pulse_cycles;
	logic [4:0] bank1_oe_delay_cycles, bank1_write_cycle_length, bank1_read_cycle_length;
	logic [7:0] ctrl_ticks, tick0;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	localparam logic [31:0] T_A = 32'h000E_59F2;
	localparam logic [31:0] T_MIN = 32'h0002_4932;
	smotr_top u_smotr_top (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .memory_ctrl_clock, .bank0_latch_used, .bank0_page_enable,
		.bank0_read_beats, .bank0_bus_width, .bank1_latch_used, .bank1_page_enable,
		.bank1_read_beats, .bank1_bus_width, .bank0_turnaround_cycles,
		.bank0_page_beat_cycles, .bank0_write_pulse_cycles, .bank0_oe_delay_cycles,
		.bank0_write_cycle_length, .bank0_read_cycle_length, .bank1_turnaround_cycles,
		.bank1_page_beat_cycles, .bank1_write_pulse_cycles, .bank1_oe_delay_cycles,
		.bank1_write_cycle_length, .bank1_read_cycle_length);
	smotr_sram_model u_smotr_sram_model (.mclk, .nrst, .memory_ctrl_clock,
		.latch_used(bank0_latch_used), .page_enable(bank0_page_enable), .page_on_mux,
		.ctrl_ticks);
	// ==========================================================
	// Clock, timeout and closing report.
	initial begin
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Register access and comparison tasks.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1 `CHK(reg_rdata, e)
		@(posedge mclk);
	endtask
	// Two system cycles for every controller cycle of a three-bit field.
	function automatic logic [4:0] sys3(input logic [2:0] f);
		sys3 = {1'b0, f, 1'b0};
	endfunction
	task automatic tim(input logic b, input logic [31:0] t, input logic pe);
		logic [4:0] pc;
		pc = pe ? sys3(t[16:14]) : 5'h00;
		`CHK(b ? bank1_turnaround_cycles : bank0_turnaround_cycles, sys3(t[19:17]))
		`CHK(b ? bank1_page_enable : bank0_page_enable, pe)
		`CHK(b ? bank1_page_beat_cycles : bank0_page_beat_cycles, pc)
		`CHK(b ? bank1_write_pulse_cycles : bank0_write_pulse_cycles, sys3(t[13:11]))
		`CHK(b ? bank1_oe_delay_cycles : bank0_oe_delay_cycles, sys3(t[10:8]))
		`CHK(b ? bank1_write_cycle_length : bank0_write_cycle_length, {t[7:4], 1'b0})
		`CHK(b ? bank1_read_cycle_length : bank0_read_cycle_length, {t[3:0], 1'b0})
	endtask
	task automatic md(input logic b, input logic lt, input logic [2:0] bl);
		`CHK(b ? bank1_latch_used : bank0_latch_used, lt)
		`CHK(b ? bank1_read_beats : bank0_read_beats, bl)
		`CHK(b ? bank1_bus_width : bank0_bus_width, 2'h1)
		`CHK(page_on_mux, 1'b0)
	endtask
	// ==========================================================
	// Test sequence.
	initial begin
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		#1 tick0 = ctrl_ticks;
		repeat (10) @(posedge mclk);
		#1 `CHK(8'(ctrl_ticks - tick0), 8'h05)
		@(posedge mclk);
		rd(smotr_pkg::ADDR_TIMING_BANK0, smotr_pkg::TIMING_RESET);
		rd(smotr_pkg::ADDR_MODE_BANK1, smotr_pkg::MODE_RESET);
		tim(1'b0, smotr_pkg::TIMING_RESET, 1'b0);
		wr(smotr_pkg::ADDR_STAGED_TIMING, T_A);
		wr(smotr_pkg::ADDR_STAGED_MODE, 32'h0000_0009);
		rd(smotr_pkg::ADDR_TIMING_BANK0, smotr_pkg::TIMING_RESET);
		wr(smotr_pkg::ADDR_COMMAND, 32'h01C0_0000);
		wr(smotr_pkg::ADDR_COMMAND, 32'h0140_0000);
		tim(1'b0, smotr_pkg::TIMING_RESET, 1'b0);
		wr(smotr_pkg::ADDR_COMMAND, 32'h0040_0000);
		tim(1'b0, T_A, 1'b1);
		md(1'b0, 1'b0, 3'h1);
		rd(smotr_pkg::ADDR_MODE_BANK0, 32'h0000_0009);
		tim(1'b1, smotr_pkg::TIMING_RESET, 1'b0);
		wr(smotr_pkg::ADDR_STAGED_MODE, 32'h0000_0809);
		wr(smotr_pkg::ADDR_COMMAND, 32'h00C0_0000);
		md(1'b1, 1'b1, 3'h1);
		tim(1'b1, T_A, 1'b0);
		wr(smotr_pkg::ADDR_STAGED_TIMING, T_MIN);
		wr(smotr_pkg::ADDR_COMMAND, 32'h0040_0000);
		tim(1'b0, T_MIN, 1'b0);
		md(1'b0, 1'b1, 3'h1);
		wr(smotr_pkg::ADDR_TIMING_BANK0, 32'h0);
		rd(smotr_pkg::ADDR_TIMING_BANK0, T_MIN);
		rd(smotr_pkg::ADDR_STAGED_MODE, 32'h0);
		rd(8'h3C, 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
